// *** rtl/pcp_pad_ctrl.sv ***
// pcp_pad_ctrl: pad drive configuration register and state-driven pull control
`timescale 1ns/1ps

module pcp_pad_ctrl
    import pcp_pkg::*;
(
    // clock, reset, enable
    input  wire logic            mclk,
    input  wire logic            rst,
    input  wire logic            ce,
    // register access from the slave serial interface
    input  wire logic [5:0]      reg_addr,
    input  wire logic [7:0]      reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_rd,
    output logic      [7:0]      reg_rdata,
    // transceiver state and auxiliary function enables
    input  wire pcp_trx_state_t  trx_state,
    input  wire logic [3:0]      aux_function_en,
    // pad controls
    output pcp_drive_t           drive,
    output logic                 clock_out_shadow_select,
    output logic      [2:0]      clock_out_rate_select,
    output pcp_input_pull_t      input_pull,
    output logic      [3:0]      aux_pulldown_en,
    output pcp_regulator_t       regulator_en
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // write and read paths decode the same single address
    function automatic logic pad_ctrl_hit(input logic [5:0] addr);
        pad_ctrl_hit = (addr == PCP_PAD_CTRL_ADDR);
    endfunction

    // code to current in mA, shared by the general and the clock pads
    function automatic logic [3:0] drive_ma(input logic [1:0] code);
        drive_ma = 4'(PCP_DRIVE_MA_STEP * ({2'h0, code} + 4'h1));
    endfunction

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    logic [7:0]      cfg_reg;
    logic [7:0]      cfg_next;

    always_comb begin
        cfg_next = cfg_reg;
        // writes to any other address fall away without side effects
        if (reg_wr && pad_ctrl_hit(reg_addr)) begin
            cfg_next = reg_wdata;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cfg_reg <= PCP_PAD_CTRL_RESET;
        end else if (ce) begin
            cfg_reg <= cfg_next;
        end
    end

    // ----------------------------------------------------------------
    // drive strength outputs
    // ----------------------------------------------------------------
    // decoded from the next register value, so a write reaches the pads
    // on its own edge rather than one cycle later
    pcp_drive_t      drive_next;

    always_comb begin
        drive_next.general_code              =
            cfg_next[PCP_GEN_DRIVE_MSB:PCP_GEN_DRIVE_LSB];
        drive_next.general_ma                = drive_ma(drive_next.general_code);
        drive_next.master_clock_output_drive =
            cfg_next[PCP_MCLK_DRIVE_MSB:PCP_MCLK_DRIVE_LSB];
        drive_next.master_clock_ma           =
            drive_ma(drive_next.master_clock_output_drive);
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            drive <= PCP_DRIVE_RESET;
        end else if (ce) begin
            drive <= drive_next;
        end
    end

    // ----------------------------------------------------------------
    // clock output fields
    // ----------------------------------------------------------------
    // only carried to the clock generator here; their meaning lives there
    logic            shadow_next;
    logic [2:0]      rate_next;

    always_comb begin
        shadow_next = cfg_next[PCP_SHADOW_SEL_BIT];
        rate_next   = cfg_next[PCP_RATE_SEL_MSB:PCP_RATE_SEL_LSB];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            clock_out_shadow_select <= PCP_PAD_CTRL_RESET[PCP_SHADOW_SEL_BIT];
            clock_out_rate_select   <=
                PCP_PAD_CTRL_RESET[PCP_RATE_SEL_MSB:PCP_RATE_SEL_LSB];
        end else if (ce) begin
            clock_out_shadow_select <= shadow_next;
            clock_out_rate_select   <= rate_next;
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    logic [7:0]      rdata_next;

    always_comb begin
        // the last read value stands until the next read strobe
        rdata_next = reg_rdata;
        if (reg_rd) begin
            // unmapped addresses read as zero; a read beside a write sees the old value
            rdata_next = pad_ctrl_hit(reg_addr) ? cfg_reg : 8'h00;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= PCP_RDATA_RESET;
        end else if (ce) begin
            reg_rdata <= rdata_next;
        end
    end

    // ----------------------------------------------------------------
    // input pull-ups and pull-downs
    // ----------------------------------------------------------------
    pcp_input_pull_t pull_next;

    always_comb begin
        pull_next = PCP_PULL_NONE;
        case (trx_state)
            PCP_ST_POWER_ON: begin
                pull_next = PCP_PULL_POWER_ON;
            end
            PCP_ST_RESET: begin
                pull_next = PCP_PULL_NONE;
            end
            PCP_ST_SLEEP,
            PCP_ST_CLOCK_ONLY_OFF,
            PCP_ST_ACTIVE: begin
                pull_next = PCP_PULL_NONE;
            end
            default: begin
                // an illegal code must never leave a pin pulled
                pull_next = PCP_PULL_NONE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            input_pull <= PCP_PULL_NONE;
        end else if (ce) begin
            input_pull <= pull_next;
        end
    end

    // ----------------------------------------------------------------
    // regulator enables
    // ----------------------------------------------------------------
    pcp_regulator_t  reg_en_next;

    always_comb begin
        reg_en_next.digital_regulator_output = 1'b1;
        reg_en_next.analog_regulator_output  = 1'b0;
        case (trx_state)
            PCP_ST_SLEEP: begin
                reg_en_next.digital_regulator_output = 1'b0;
            end
            PCP_ST_ACTIVE: begin
                reg_en_next.analog_regulator_output = 1'b1;
            end
            PCP_ST_POWER_ON,
            PCP_ST_RESET,
            PCP_ST_CLOCK_ONLY_OFF: begin
                reg_en_next.analog_regulator_output = 1'b0;
            end
            default: begin
                // an illegal code keeps the digital side alive, the analog side down
                reg_en_next.analog_regulator_output = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            regulator_en <= PCP_REGULATOR_RESET;
        end else if (ce) begin
            regulator_en <= reg_en_next;
        end
    end

    // ----------------------------------------------------------------
    // auxiliary output pull-downs
    // ----------------------------------------------------------------
    logic [3:0]      aux_next;

    always_comb begin
        // a disabled function leaves its output pulled low, never floating
        aux_next = ~aux_function_en;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            aux_pulldown_en <= PCP_AUX_PULLDOWN_RESET;
        end else if (ce) begin
            aux_pulldown_en <= aux_next;
        end
    end

endmodule

// *** rtl/pcp_pkg.sv ***
// pcp_pkg: constants and types for pad configuration and pull control
package pcp_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [5:0] PCP_PAD_CTRL_ADDR  = 6'h03;
    localparam logic [7:0] PCP_PAD_CTRL_RESET = 8'h19;
    localparam logic [7:0] PCP_RDATA_RESET    = 8'h00;

    // field positions of the pad and clock output control register
    localparam int PCP_GEN_DRIVE_MSB   = 7;
    localparam int PCP_GEN_DRIVE_LSB   = 6;
    localparam int PCP_MCLK_DRIVE_MSB  = 5;
    localparam int PCP_MCLK_DRIVE_LSB  = 4;
    localparam int PCP_SHADOW_SEL_BIT  = 3;
    localparam int PCP_RATE_SEL_MSB    = 2;
    localparam int PCP_RATE_SEL_LSB    = 0;

    // drive strength in mA for codes 0..3
    localparam logic [3:0] PCP_DRIVE_MA_STEP = 4'h2;

    // ----------------------------------------------------------------
    // transceiver state, one-hot
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        PCP_ST_POWER_ON       = 5'h01,
        PCP_ST_SLEEP          = 5'h02,
        PCP_ST_RESET          = 5'h04,
        PCP_ST_CLOCK_ONLY_OFF = 5'h08,
        PCP_ST_ACTIVE         = 5'h10
    } pcp_trx_state_t;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic chip_reset_pullup;
        logic spi_select_pullup;
        logic spi_clock_pulldown;
        logic spi_data_in_pulldown;
        logic sleep_transmit_control_pulldown;
    } pcp_input_pull_t;

    localparam pcp_input_pull_t PCP_PULL_NONE     = 5'h00;
    localparam pcp_input_pull_t PCP_PULL_POWER_ON = 5'h1F;

    typedef struct packed {
        logic [1:0] general_code;
        logic [3:0] general_ma;
        logic [1:0] master_clock_output_drive;
        logic [3:0] master_clock_ma;
    } pcp_drive_t;

    // general 2 mA (code 0), clock 4 mA (code 1)
    localparam pcp_drive_t PCP_DRIVE_RESET = 12'h094;

    typedef struct packed {
        logic digital_regulator_output;
        logic analog_regulator_output;
    } pcp_regulator_t;

    // reset state of the transceiver: digital side on, analog side off
    localparam pcp_regulator_t PCP_REGULATOR_RESET = 2'h2;

    // aux outputs: [0] antenna_switch_out, [1] antenna_switch_out_inv,
    // [2] front_end_indicator, [3] front_end_indicator_inv
    localparam logic [3:0] PCP_AUX_PULLDOWN_RESET = 4'hF;

endpackage

// *** tb/pcp_host_model.sv ***
// pcp_host_model: register master in place of the serial slave
`timescale 1ns/1ps
module pcp_host_model (
    input  wire logic       mclk,
    output logic      [5:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd
);
    initial {reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
    // host may write and read all eight bits
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge mclk);
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, d};
        @(posedge mclk);
        // released lines show the inverse so a stale value cannot pass
        {reg_wr, reg_rd, reg_addr, reg_wdata} <= {2'b00, ~a, ~d};
    endtask
endmodule

// *** tb/pcp_pad_ctrl_properties.sv ***
// pcp_pad_ctrl_properties: port assertions for the pad control bank
`timescale 1ns/1ps
module pcp_pad_ctrl_properties
    import pcp_pkg::*;
(
    input wire logic            mclk,
    input wire logic            rst,
    input wire logic            ce,
    input wire logic [5:0]      reg_addr,
    input wire logic [7:0]      reg_wdata,
    input wire logic            reg_wr,
    input wire pcp_trx_state_t  trx_state,
    input wire logic [3:0]      aux_function_en,
    input wire pcp_drive_t      drive,
    input wire logic            clock_out_shadow_select,
    input wire logic [2:0]      clock_out_rate_select,
    input wire pcp_input_pull_t input_pull,
    input wire logic [3:0]      aux_pulldown_en,
    input wire pcp_regulator_t  regulator_en
);
    wire hit = ce && reg_wr && reg_addr == PCP_PAD_CTRL_ADDR;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    chk_gen_drive: assert property (hit |=> drive.general_code == $past(reg_wdata[7:6]))
        else $error("general drive code not loaded");
    chk_clk_drive: assert property (
        hit |=> drive.master_clock_output_drive == $past(reg_wdata[5:4]))
        else $error("clock drive code not loaded");
    chk_out_fields: assert property (
        hit |=> {clock_out_shadow_select, clock_out_rate_select} == $past(reg_wdata[3:0]))
        else $error("clock output fields not loaded");
    chk_drive_ma: assert property (
        drive.master_clock_ma == {1'b0, drive.master_clock_output_drive, 1'b0} + 4'h2)
        else $error("clock drive current wrong");
    chk_pull_on: assert property (
        ce && trx_state == PCP_ST_POWER_ON |=> input_pull == PCP_PULL_POWER_ON)
        else $error("power-on pulls missing");
    chk_pull_off: assert property (
        ce && trx_state != PCP_ST_POWER_ON |=> input_pull == PCP_PULL_NONE)
        else $error("pulls left connected");
    chk_aux_low: assert property (ce |=> aux_pulldown_en == ~$past(aux_function_en))
        else $error("aux pull-down wrong");
    chk_reg_state: assert property (
        ce |=> regulator_en == {$past(trx_state) != PCP_ST_SLEEP,
                                $past(trx_state) == PCP_ST_ACTIVE})
        else $error("regulator enables wrong");
endmodule
bind pcp_pad_ctrl pcp_pad_ctrl_properties u_chk (.*);

// *** tb/tb_pcp_pad_ctrl.sv ***
// tb_pcp_pad_ctrl: self-checking bench for the pad control bank
`timescale 1ns/1ps
module tb_pcp_pad_ctrl;
    import pcp_pkg::*;
    logic mclk = 0, rst = 1, ce = 1, reg_wr, reg_rd, clock_out_shadow_select;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, cfg;
    logic [2:0] clock_out_rate_select;
    logic [3:0] aux_function_en = 4'h0, aux_pulldown_en;
    pcp_trx_state_t trx_state = PCP_ST_RESET;
    pcp_drive_t drive;
    pcp_input_pull_t input_pull;
    pcp_regulator_t regulator_en;
    int fail_count = 0, checks = 0;
    integer seed = 32'h0199;
    logic [5:0] addr;
    logic [7:0] data;
    logic [10:0] exp_pins;
    always #10 mclk = ~mclk;
    pcp_host_model HOST (.*);
    pcp_pad_ctrl DUT (.*);
    function automatic logic [11:0] exp_drive(input logic [7:0] c);
        return {c[7:6], {1'b0, c[7:6], 1'b0} + 4'h2, c[5:4], {1'b0, c[5:4], 1'b0} + 4'h2};
    endfunction
    task automatic chk(input string n, input logic [11:0] seen, input logic [11:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic wr_chk(input logic [5:0] a, input logic [7:0] v);
        HOST.acc(1'b1, a, v);
        if (a == 6'h03) cfg = v;
        @(negedge mclk);
        chk("drive", drive, exp_drive(cfg));
        chk("clock fields", {clock_out_shadow_select, clock_out_rate_select}, cfg[3:0]);
        HOST.acc(1'b0, a, 8'h00);
        @(negedge mclk);
        chk("read back", reg_rdata, (a == 6'h03) ? cfg : 8'h00);
    endtask
    task automatic reset_check;
        @(posedge mclk);
        rst <= 1;
        repeat (4) @(posedge mclk);
        rst <= 0;
        cfg = 8'h19;
        @(negedge mclk);
        chk("reset drive", drive, exp_drive(cfg));
        chk("reset fields", {clock_out_shadow_select, clock_out_rate_select}, cfg[3:0]);
        chk("reset pins", {input_pull, aux_pulldown_en, regulator_en}, {5'h00, 4'hF, 2'h2});
        HOST.acc(1'b0, 6'h03, 8'h00);
        @(negedge mclk);
        chk("reset read", reg_rdata, 8'h19);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        reset_check;
        $display("reset test done");
        for (int i = 0; i < 14; i++) begin
            addr = (i % 4 == 3) ? (6'($random(seed)) | 6'h20) : 6'h03;
            data = (i < 2) ? {8{i[0]}} : 8'($random(seed));
            wr_chk(addr, data);
        end
        @(posedge mclk);
        ce <= 0;
        HOST.acc(1'b1, 6'h03, ~cfg);
        @(negedge mclk);
        chk("frozen drive", drive, exp_drive(cfg));
        @(posedge mclk);
        ce <= 1;
        HOST.acc(1'b0, 6'h03, 8'h00);
        @(negedge mclk);
        chk("frozen read", reg_rdata, cfg);
        $display("register test done");
        reset_check;
        $display("mid-run reset test done");
        // the sixth step of each round drives an illegal all-zero state code
        for (int i = 0; i < 24; i++) begin
            @(posedge mclk);
            trx_state <= pcp_trx_state_t'(5'(1 << (i % 6)));
            aux_function_en <= 4'($random(seed));
            repeat (2) @(negedge mclk);
            exp_pins = {(trx_state == PCP_ST_POWER_ON) ? PCP_PULL_POWER_ON : PCP_PULL_NONE,
                        ~aux_function_en, trx_state != PCP_ST_SLEEP,
                        trx_state == PCP_ST_ACTIVE};
            chk("pins", {input_pull, aux_pulldown_en, regulator_en}, exp_pins);
        end
        $display("state test done");
        final_report;
    end
    initial begin
        #100000;
        fail_count++;
        final_report;
    end
endmodule
